/* File: hdl/fmc_pkg.sv */
// Purpose: Constants and types for the flash mode and clock register bank.
// Assumes: AHB-Lite word access, register index times four is the byte address.
// Notes: Field positions, keys and reset values live here only.
package fmc_pkg;
   // Register indices; byte address is four times the index.
   localparam logic [29:0] FMC_IDX_MODE = 30'h0000_0128;
   localparam logic [29:0] FMC_IDX_CLK = 30'h0000_012A;
   localparam logic [29:0] FMC_IDX_STAT = 30'h0000_012E;
   // Key handling and reset values.
   localparam logic [7:0] FMC_KEY_WRITE = 8'hA5;
   localparam logic [7:0] FMC_KEY_READ = 8'h96;
   localparam logic [15:0] FMC_MODE_RST = 16'h9600;
   localparam logic [15:0] FMC_CLK_RST = 16'h9642;
   // Mode register fields.
   localparam int FMC_BLK_POS = 7;
   localparam int FMC_WRT_POS = 6;
   localparam int FMC_BULK_ERASE_BIT_POS = 2;
   localparam int FMC_ERASE_POS = 1;
   // Clock register fields.
   localparam int FMC_SRC_LSB = 6;
   localparam int FMC_DIV_MSB = 5;
   localparam logic [1:0] FMC_SRC_RSVD = 2'h0;
   localparam logic [1:0] FMC_SRC_MAIN = 2'h1;
   // Status register bit positions.
   localparam int FMC_ST_ACCV = 0;
   localparam int FMC_ST_KEY_VIOLATION_FLAG = 1;
   localparam int FMC_ST_BUSY = 2;
   localparam int FMC_ST_LOCK = 3;
   localparam int FMC_ST_EMERGENCY_EXIT = 4;
   localparam int FMC_ST_OPACT = 5;
   // Bus encodings.
   localparam logic [2:0] FMC_HSIZE_WORD = 3'h2;
   // Erase scope codes.
   typedef enum logic [1:0] {
      FMC_ER_NONE = 2'h0,
      FMC_ER_SEG = 2'h1,
      FMC_ER_MAIN = 2'h2,
      FMC_ER_ALL = 2'h3
   } fmc_erase_t;
   // Stored mode and clock fields.
   typedef struct packed {
      logic blk;
      logic write_mode_bit;
      logic bulk_erase_bit;
      logic erase;
   } fmc_mode_t;
   typedef struct packed {
      logic [1:0] src;
      logic [5:0] div;
   } fmc_clk_t;
   typedef enum logic [1:0] {FMC_IDLE, FMC_WRITE, FMC_RWAIT, FMC_RDATA} fmc_bus_t;
endpackage

/* File: hdl/fmc_regs.sv */
// Purpose: Password-protected flash mode and clock control registers on AHB-Lite.
// Assumes: One master, word transfers, status inputs synchronous to clk_in.
// Notes: Reads take one wait state; writes take none.
// Contract
// - Upper byte of both control registers always reads 96h.
// - Writes must carry key A5h; any other key requests a system reset.
// - Emergency exit clears block, write, bulk erase and erase bits.
// - Write-mode bit enables writing when 1, disables all writes when 0.
// - Erase bits decode to none, segment, or all main segments.
// - Both erase bits erase main plus info unless info lock set.
// - Mode register reserved bits 5-3 and 0 read zero.
// - Source 00 reserved, 01 main clock, 10 and 11 subsystem clock.
// - Divisor is divider field plus one, 1 to 64.
// - Mode register at 0128h resets to 9600h.
// - Clock register at 012Ah resets to 9642h, main clock, divider 2.
// - Mode write during erase or single write sets access violation.
// - Clock write while busy sets access violation.
// - Wrong key also sets key violation flag.
// - Emergency exit stops activity and clears the whole mode register.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module fmc_regs
   import fmc_pkg::*;
(
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // AHB-Lite slave.
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic hready_in,
   input wire logic [31:0] hwdata_in,
   output logic hreadyout_out,
   output logic hresp_out,
   output logic [31:0] hrdata_out,
   // Controller status.
   input wire logic emergency_exit_in,
   input wire logic info_segment_lock_in,
   input wire logic busy_in,
   input wire logic op_active_in,
   input wire logic sub_clk_en_in,
   // Mode and clock outputs.
   output logic write_mode_out,
   output logic block_write_out,
   output fmc_erase_t erase_kind_out,
   output logic flash_clk_en_out,
   // Violations and reset request.
   output logic access_violation_flag_out,
   output logic key_violation_flag_out,
   output logic power_up_clear_reset_out
);
   fmc_bus_t state_reg;
   logic [29:0] idx_reg;
   logic word_reg;
   fmc_mode_t mode_reg;
   fmc_clk_t clk_reg;
   logic [5:0] cnt_reg;
   logic accept;
   logic wr_stb;
   logic key_ok;
   logic mode_hit;
   logic clk_hit;
   logic stat_hit;
   logic mode_wr;
   logic clk_wr;
   logic accv_set;
   logic key_violation_flag_set;
   logic src_tick;

   // Register index match, used for every decode of the latched address.
   function automatic logic hit(input logic [29:0] idx, input logic [29:0] want);
      hit = (idx == want);
   endfunction

   // Erase scope from the two erase bits and the info segment lock.
   function automatic fmc_erase_t erase_scope(input fmc_mode_t m, input logic lock);
      if (m.bulk_erase_bit && m.erase)
      begin
         erase_scope = lock ? FMC_ER_MAIN : FMC_ER_ALL;
      end
      else if (m.bulk_erase_bit)
      begin
         erase_scope = FMC_ER_MAIN;
      end
      else if (m.erase)
      begin
         erase_scope = FMC_ER_SEG;
      end
      else
      begin
         erase_scope = FMC_ER_NONE;
      end
   endfunction

   // Address phase acceptance and data phase write decode.
   assign accept = hsel_in && hready_in && htrans_in[1] && (state_reg != FMC_RWAIT);
   assign wr_stb = (state_reg == FMC_WRITE) && word_reg;
   assign key_ok = (hwdata_in[15:8] == FMC_KEY_WRITE);
   assign mode_hit = hit(idx_reg, FMC_IDX_MODE);
   assign clk_hit = hit(idx_reg, FMC_IDX_CLK);
   assign stat_hit = hit(idx_reg, FMC_IDX_STAT);
   assign key_violation_flag_set = wr_stb && (mode_hit || clk_hit) && !key_ok;
   assign accv_set = wr_stb && key_ok && ((mode_hit && op_active_in) || (clk_hit && busy_in));
   assign mode_wr = wr_stb && mode_hit && key_ok && !op_active_in;
   assign clk_wr = wr_stb && clk_hit && key_ok && !busy_in;

   // Bus phase tracking; reads wait one cycle so a write just before is seen.
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_reg <= FMC_IDLE;
         idx_reg <= 30'h0000_0000;
         word_reg <= 1'b0;
         hreadyout_out <= 1'b1;
      end
      else
      begin
         unique case (state_reg)
            FMC_RWAIT:
            begin
               state_reg <= FMC_RDATA;
               hreadyout_out <= 1'b1;
            end
            FMC_IDLE, FMC_WRITE, FMC_RDATA:
            begin
               if (accept)
               begin
                  state_reg <= hwrite_in ? FMC_WRITE : FMC_RWAIT;
                  idx_reg <= haddr_in[31:2];
                  word_reg <= (hsize_in == FMC_HSIZE_WORD);
                  hreadyout_out <= hwrite_in;
               end
               else
               begin
                  state_reg <= FMC_IDLE;
               end
            end
         endcase
      end
   end

   // The response is always OKAY.
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         hresp_out <= 1'b0;
      end
      else
      begin
         hresp_out <= 1'b0;
      end
   end

   // Read data, loaded in the wait cycle; unmapped indices read zero.
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         hrdata_out <= 32'h0000_0000;
      end
      else if (state_reg == FMC_RWAIT)
      begin
         hrdata_out <= 32'h0000_0000;
         if (mode_hit)
         begin
            hrdata_out[15:8] <= FMC_KEY_READ;
            hrdata_out[FMC_BLK_POS] <= mode_reg.blk;
            hrdata_out[FMC_WRT_POS] <= mode_reg.write_mode_bit;
            hrdata_out[FMC_BULK_ERASE_BIT_POS] <= mode_reg.bulk_erase_bit;
            hrdata_out[FMC_ERASE_POS] <= mode_reg.erase;
         end
         else if (clk_hit)
         begin
            hrdata_out[15:0] <= {FMC_KEY_READ, clk_reg};
         end
         else if (stat_hit)
         begin
            hrdata_out[FMC_ST_ACCV] <= access_violation_flag_out;
            hrdata_out[FMC_ST_KEY_VIOLATION_FLAG] <= key_violation_flag_out;
            hrdata_out[FMC_ST_BUSY] <= busy_in;
            hrdata_out[FMC_ST_LOCK] <= info_segment_lock_in;
            hrdata_out[FMC_ST_EMERGENCY_EXIT] <= emergency_exit_in;
            hrdata_out[FMC_ST_OPACT] <= op_active_in;
         end
      end
   end

   // Mode register; emergency exit beats a write in the same cycle.
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         mode_reg <= fmc_mode_t'(4'h0);
      end
      else if (emergency_exit_in)
      begin
         mode_reg <= fmc_mode_t'(4'h0);
      end
      else if (mode_wr)
      begin
         mode_reg.blk <= hwdata_in[FMC_BLK_POS];
         mode_reg.write_mode_bit <= hwdata_in[FMC_WRT_POS];
         mode_reg.bulk_erase_bit <= hwdata_in[FMC_BULK_ERASE_BIT_POS];
         mode_reg.erase <= hwdata_in[FMC_ERASE_POS];
      end
   end

   // Clock register; a reserved source code is stored and simply yields no ticks.
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         clk_reg <= fmc_clk_t'(FMC_CLK_RST[7:0]);
      end
      else if (clk_wr)
      begin
         clk_reg <= fmc_clk_t'(hwdata_in[7:0]);
      end
   end

   // Decoded mode outputs, registered so the ports come from flip-flops.
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         write_mode_out <= 1'b0;
         block_write_out <= 1'b0;
         erase_kind_out <= FMC_ER_NONE;
      end
      else
      begin
         write_mode_out <= mode_reg.write_mode_bit;
         block_write_out <= mode_reg.blk && mode_reg.write_mode_bit;
         erase_kind_out <= erase_scope(mode_reg, info_segment_lock_in);
      end
   end

   // Source select; the subsystem clock arrives as an enable pulse.
   assign src_tick = (clk_reg.src == FMC_SRC_MAIN) ? 1'b1 : sub_clk_en_in;

   // Timing generator divider: one tick every div+1 source cycles.
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cnt_reg <= 6'h00;
         flash_clk_en_out <= 1'b0;
      end
      else if (clk_reg.src == FMC_SRC_RSVD)
      begin
         cnt_reg <= 6'h00;
         flash_clk_en_out <= 1'b0;
      end
      else if (src_tick && (cnt_reg == clk_reg.div))
      begin
         cnt_reg <= 6'h00;
         flash_clk_en_out <= 1'b1;
      end
      else
      begin
         cnt_reg <= src_tick ? cnt_reg + 6'h01 : cnt_reg;
         flash_clk_en_out <= 1'b0;
      end
   end

   // Sticky violation flags, write one to clear; a new event beats the clear.
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         access_violation_flag_out <= 1'b0;
         key_violation_flag_out <= 1'b0;
      end
      else
      begin
         if (accv_set)
         begin
            access_violation_flag_out <= 1'b1;
         end
         else if (wr_stb && stat_hit && hwdata_in[FMC_ST_ACCV])
         begin
            access_violation_flag_out <= 1'b0;
         end
         if (key_violation_flag_set)
         begin
            key_violation_flag_out <= 1'b1;
         end
         else if (wr_stb && stat_hit && hwdata_in[FMC_ST_KEY_VIOLATION_FLAG])
         begin
            key_violation_flag_out <= 1'b0;
         end
      end
   end

   // Reset request pulse, raised with the key flag in the same cycle.
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         power_up_clear_reset_out <= 1'b0;
      end
      else
      begin
         power_up_clear_reset_out <= key_violation_flag_set;
      end
   end

   // Checks on the behaviour above.
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);

   AST_READ_KEY: assert property ((state_reg == FMC_RDATA) && (mode_hit || clk_hit)
      |-> hrdata_out[15:8] == FMC_KEY_READ)
      else $error("control register upper byte not 96h");
   AST_BAD_KEY: assert property (key_violation_flag_set
      |=> power_up_clear_reset_out && key_violation_flag_out ##1 !power_up_clear_reset_out)
      else $error("wrong key did not pulse reset request and flag");
   AST_EMERGENCY_EXIT: assert property (emergency_exit_in |=> mode_reg == fmc_mode_t'(4'h0)
      ##1 !write_mode_out && !block_write_out)
      else $error("emergency exit did not clear mode bits");
   AST_WRT_OFF: assert property (!mode_reg.write_mode_bit |=> !write_mode_out && !block_write_out)
      else $error("write mode active with write bit clear");
   AST_SEG: assert property (!mode_reg.bulk_erase_bit && mode_reg.erase
      |=> erase_kind_out == FMC_ER_SEG)
      else $error("segment erase misdecoded");
   AST_LOCKED: assert property (mode_reg.bulk_erase_bit && mode_reg.erase && info_segment_lock_in
      |=> erase_kind_out == FMC_ER_MAIN)
      else $error("locked mass erase reaches info memory");
   AST_RSVD_ZERO: assert property ((state_reg == FMC_RDATA) && mode_hit
      |-> hrdata_out[5:3] == 3'h0 && !hrdata_out[0])
      else $error("mode reserved bits read nonzero");
   AST_NO_SRC: assert property (clk_reg.src == FMC_SRC_RSVD |=> !flash_clk_en_out)
      else $error("tick with reserved source");
   // Divide by three: ticks three cycles apart while no clock write lands in between.
   AST_DIV3: assert property (flash_clk_en_out && clk_reg.src == FMC_SRC_MAIN
      && clk_reg.div == 6'h02 && !clk_wr ##1 !clk_wr
      |-> !flash_clk_en_out ##1 !flash_clk_en_out ##1 flash_clk_en_out)
      else $error("divide by three spacing wrong");
   AST_MODE_BUSY: assert property (wr_stb && mode_hit && key_ok && op_active_in
      && !emergency_exit_in
      |=> access_violation_flag_out && $stable(mode_reg))
      else $error("mode write during operation not refused");
   AST_CLK_BUSY: assert property (wr_stb && clk_hit && key_ok && busy_in
      |=> access_violation_flag_out && $stable(clk_reg))
      else $error("clock write while busy not refused");

   COV_BAD_KEY: cover property (key_violation_flag_set ##1 power_up_clear_reset_out);
   COV_EMERGENCY_EXIT: cover property (mode_reg.write_mode_bit ##1 emergency_exit_in);
   COV_READ: cover property ((state_reg == FMC_RWAIT) ##1 hreadyout_out);
   COV_MASS: cover property (erase_kind_out == FMC_ER_ALL);
endmodule

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the flash mode and clock register bank.
// Assumes: Word transfers on AHB-Lite, hready tied back to hreadyout.
// Notes: The status register is used only to clear the sticky flags.
`timescale 1ns/1ps
module tb_top;
   import fmc_pkg::*;
   localparam logic [31:0] A_MODE = 32'h0000_04A0;
   localparam logic [31:0] A_CLK = 32'h0000_04A8;
   localparam logic [31:0] A_STAT = 32'h0000_04B8;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic hsel_in = 1'b0;
   logic [31:0] haddr_in = 32'h0000_0000;
   logic [1:0] htrans_in = 2'h0;
   logic hwrite_in = 1'b0;
   logic [2:0] hsize_in = 3'h2;
   logic [31:0] hwdata_in = 32'h0000_0000;
   logic hreadyout_out, hresp_out, write_mode_out, block_write_out, flash_clk_en_out;
   logic [31:0] hrdata_out;
   fmc_erase_t erase_kind_out;
   logic access_violation_flag_out, key_violation_flag_out, power_up_clear_reset_out;
   logic emergency_exit_in = 1'b0;
   logic info_segment_lock_in = 1'b0;
   logic busy_in = 1'b0;
   logic op_active_in = 1'b0;
   logic sub_clk_en_in = 1'b0;
   logic [1:0] sub_div = 2'h0;
   int fail_count = 0;
   int n_compared = 0;
   int tick_count = 0;
   int puc_count = 0;
   logic [31:0] rd;
   fmc_regs i_fmc_regs (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
      .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
      .hsize_in(hsize_in), .hready_in(hreadyout_out), .hwdata_in(hwdata_in),
      .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .hrdata_out(hrdata_out),
      .emergency_exit_in(emergency_exit_in), .info_segment_lock_in(info_segment_lock_in),
      .busy_in(busy_in), .op_active_in(op_active_in), .sub_clk_en_in(sub_clk_en_in),
      .write_mode_out(write_mode_out), .block_write_out(block_write_out),
      .erase_kind_out(erase_kind_out), .flash_clk_en_out(flash_clk_en_out),
      .access_violation_flag_out(access_violation_flag_out),
      .key_violation_flag_out(key_violation_flag_out),
      .power_up_clear_reset_out(power_up_clear_reset_out));
   // Clock of 25 ns period.
   always #12.5 clk_in = ~clk_in;
   // Subsystem clock enable, one pulse every third cycle.
   always @(posedge clk_in)
   begin
      sub_div <= (sub_div == 2'h2) ? 2'h0 : sub_div + 2'h1;
      sub_clk_en_in <= (sub_div == 2'h2);
   end
   // Pulses are counted mid-cycle so the count never races the main sequence.
   always @(negedge clk_in)
   begin
      if (flash_clk_en_out === 1'b1)
         tick_count++;
      if (power_up_clear_reset_out === 1'b1)
         puc_count++;
   end
   // Comparison of bus words.
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Comparison of status outputs and counts.
   task automatic chk_sig(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Waits for hready at a rising edge; a missing answer is a mismatch.
   task automatic wait_ready;
      int n;
      n = 0;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (hreadyout_out !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         fail_count++;
         $display("[FAIL] %0t bus never ready", $time);
         wrap_up();
      end
   endtask
   task automatic bus_cycle(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel_in <= 1'b1;
      htrans_in <= 2'h2;
      haddr_in <= a;
      hwrite_in <= w;
      hsize_in <= FMC_HSIZE_WORD;
      wait_ready();
      htrans_in <= 2'h0;
      hwdata_in <= d;
      wait_ready();
      rd = hrdata_out;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic clear_flags;
      bus_cycle(A_STAT, 1'b1, 32'h0000_0003);
      settle(2);
   endtask
   // Reset values, key byte on read and an unmapped place.
   task automatic t_reset;
      bus_cycle(A_MODE, 1'b0, 32'h0000_0000);
      chk_word(rd, 32'h0000_9600, "mode reset");
      bus_cycle(A_CLK, 1'b0, 32'h0000_0000);
      chk_word(rd, 32'h0000_9642, "clock reset");
      bus_cycle(32'h0000_04A4, 1'b1, 32'h0000_A5FF);
      bus_cycle(32'h0000_04A4, 1'b0, 32'h0000_0000);
      chk_word(rd, 32'h0000_0000, "unmapped");
      chk_sig({6'h0, hresp_out, erase_kind_out == FMC_ER_NONE}, 8'h01, "idle out");
   endtask
   // Mode fields, reserved bits and every erase decode.
   task automatic t_mode;
      fmc_erase_t ek[5] = '{FMC_ER_NONE, FMC_ER_SEG, FMC_ER_MAIN, FMC_ER_ALL, FMC_ER_MAIN};
      bus_cycle(A_MODE, 1'b1, 32'h0000_A5FF);
      bus_cycle(A_MODE, 1'b0, 32'h0000_0000);
      chk_word(rd, 32'h0000_96C6, "mode readback");
      chk_sig({6'h0, write_mode_out, block_write_out}, 8'h03, "block on");
      for (int i = 0; i < 5; i++)
      begin
         info_segment_lock_in <= (i == 4);
         bus_cycle(A_MODE, 1'b1, 32'h0000_A540 | (32'((i > 3) ? 3 : i) << 1));
         settle(2);
         chk_sig({6'h0, erase_kind_out}, {6'h0, ek[i]}, "erase decode");
      end
      bus_cycle(A_MODE, 1'b1, 32'h0000_A580);
      settle(2);
      chk_sig({6'h0, write_mode_out, block_write_out}, 8'h00, "block without write");
   endtask
   // Emergency exit clears everything in the mode register.
   task automatic t_emergency_exit;
      bus_cycle(A_MODE, 1'b1, 32'h0000_A5C6);
      emergency_exit_in <= 1'b1;
      settle(3);
      emergency_exit_in <= 1'b0;
      chk_sig({5'h0, write_mode_out, block_write_out, erase_kind_out != FMC_ER_NONE},
              8'h00, "exit outputs");
      bus_cycle(A_MODE, 1'b0, 32'h0000_0000);
      chk_word(rd, 32'h0000_9600, "exit readback");
   endtask
   // Wrong key: one reset request, key flag, nothing stored.
   task automatic t_key;
      int p0;
      p0 = puc_count;
      bus_cycle(A_MODE, 1'b1, 32'h0000_5AC6);
      settle(3);
      chk_sig(8'(puc_count - p0), 8'h01, "reset pulses");
      chk_sig({7'h0, key_violation_flag_out}, 8'h01, "key flag");
      bus_cycle(A_MODE, 1'b0, 32'h0000_0000);
      chk_word(rd, 32'h0000_9600, "mode kept");
      clear_flags();
      chk_sig({6'h0, key_violation_flag_out, access_violation_flag_out}, 8'h00, "flags clear");
   endtask
   // Writes refused while an operation runs or the generator is busy.
   task automatic t_viol;
      op_active_in <= 1'b1;
      bus_cycle(A_MODE, 1'b1, 32'h0000_A5C0);
      settle(2);
      op_active_in <= 1'b0;
      chk_sig({6'h0, key_violation_flag_out, access_violation_flag_out}, 8'h01, "mode acc");
      bus_cycle(A_MODE, 1'b0, 32'h0000_0000);
      chk_word(rd, 32'h0000_9600, "mode refused");
      clear_flags();
      busy_in <= 1'b1;
      bus_cycle(A_CLK, 1'b1, 32'h0000_A5C3);
      bus_cycle(A_CLK, 1'b0, 32'h0000_0000);
      busy_in <= 1'b0;
      chk_word(rd, 32'h0000_9642, "clock refused");
      chk_sig({7'h0, access_violation_flag_out}, 8'h01, "clock acc");
      clear_flags();
   endtask
   // Source select and divider, ticks counted over whole periods.
   task automatic t_clock;
      logic [7:0] cv[6] = '{8'h43, 8'h40, 8'h7F, 8'h81, 8'hC1, 8'h03};
      int win[6] = '{40, 40, 128, 60, 60, 40};
      int nt[6] = '{10, 40, 2, 10, 10, 0};
      int t0;
      for (int i = 0; i < 6; i++)
      begin
         bus_cycle(A_CLK, 1'b1, {16'h0000, FMC_KEY_WRITE, cv[i]});
         bus_cycle(A_CLK, 1'b0, 32'h0000_0000);
         chk_word(rd, {16'h0000, FMC_KEY_READ, cv[i]}, "clock readback");
         settle(200);
         t0 = tick_count;
         settle(win[i]);
         chk_sig(8'(tick_count - t0), 8'(nt[i]), "tick count");
      end
   endtask
   // Hang guard, far beyond the under two thousand cycles the run needs.
   initial
   begin
      #(25 * 20000);
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up();
   end
   initial
   begin
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      t_reset();
      t_mode();
      t_emergency_exit();
      t_key();
      t_viol();
      t_clock();
      wrap_up();
   end
endmodule
